// ===== rtl/probe_cfg_pkg.sv
// constants and enumerations shared by the probe configuration block
package probe_cfg_pkg;
    localparam int          CS_COUNT        = 4;
    localparam int          CS_IDX_W        = 2;
    localparam int          BOOT_WORD_W     = 32;
    localparam logic [1:0]  CS_SEL_RESET    = 2'h2;
    localparam logic [1:0]  CS0_MAP_RESET   = 2'h0;
    localparam logic        OVR_RESET       = 1'b0;
    localparam logic        FLASH_PROGRAM_ENABLE_LINE_RESET      = 1'b0;
    localparam logic        PWRON_RESET     = 1'b1;
    localparam logic [31:0] BOOT_WORD_RESET = 32'h0000_0000;
    typedef enum logic [2:0] {
        MODE_EMU_INIT,
        MODE_EMU_NOINIT,
        MODE_RAM_NOINIT,
        MODE_RAM_INIT,
        MODE_DISABLED
    } usage_mode_e;
    typedef enum {
        ST_LOAD,
        ST_RESET,
        ST_BOOT,
        ST_RUN
    } probe_state_e;
endpackage

// ===== rtl/sync2.sv
// two flip-flop synchroniser for one level
`timescale 1ns/100ps
module sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_r;
    logic sync_r;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // start at the pin's idle level so no false edge follows reset
            meta_r <= RESET_VAL;
            sync_r <= RESET_VAL;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end
    assign o_sync = sync_r;
endmodule

// ===== rtl/probe_ecu_config.sv
// configuration-driven attachment of the emulator probe to the controller bus
`timescale 1ns/100ps
module probe_ecu_config
    import probe_cfg_pkg::*;
(
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_reset_n,
    // configuration from nonvolatile storage
    input  wire logic                   i_cfg_valid,
    input  wire logic [CS_IDX_W-1:0]    i_cfg_probe_cs,
    input  wire logic [CS_IDX_W-1:0]    i_cfg_cs0_map,
    input  wire logic                   i_cfg_boot_override,
    input  wire logic [BOOT_WORD_W-1:0] i_cfg_boot_word,
    input  wire logic                   i_cfg_flash_write_en,
    input  wire logic                   i_cfg_power_on_active,
    input  wire logic [2:0]             i_cfg_usage_mode,
    // controller pins (asynchronous)
    input  wire logic                   i_ecu_reset_n,
    input  wire logic                   i_ecu_chip_select_zero_n,
    input  wire logic                   i_ecu_chip_select_one_n,
    input  wire logic                   i_ecu_chip_select_two_n,
    input  wire logic                   i_ecu_chip_select_three_n,
    input  wire logic                   i_ecu_write_n,
    input  wire logic                   i_ecu_trigger_hit,
    input  wire logic                   i_power_fail,
    // outputs
    output logic [CS_COUNT-1:0]         o_cs_route_n,
    output logic                        o_mem_select,
    output logic [BOOT_WORD_W-1:0]      o_boot_data,
    output logic                        o_boot_data_oe_n,
    output logic                        o_boot_word_select_strobe_o,
    output logic                        o_boot_word_select_strobe_oe_n,
    output logic                        o_flash_program_enable_line,
    output logic                        o_service_enable,
    output logic                        o_restore_start,
    output logic                        o_probe_enabled
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [CS_COUNT-1:0] cs_n_raw;
    logic [CS_COUNT-1:0] cs_n_s;
    logic                rst_s;
    logic                wr_s;
    logic                trig_s;
    logic                pf_s;
    assign cs_n_raw = {i_ecu_chip_select_three_n, i_ecu_chip_select_two_n,
                       i_ecu_chip_select_one_n, i_ecu_chip_select_zero_n};
    genvar g;
    generate
        for (g = 0; g < CS_COUNT; g++) begin : g_cs
            sync2 #(.RESET_VAL(1'b1)) u_cs (
                .i_clk_sys (i_clk_sys),
                .i_reset_n (i_reset_n),
                .i_async   (cs_n_raw[g]),
                .o_sync    (cs_n_s[g])
            );
        end
    endgenerate
    sync2 u_rst (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
                 .i_async(i_ecu_reset_n), .o_sync(rst_s));
    sync2 #(.RESET_VAL(1'b1)) u_wr (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
                .i_async(i_ecu_write_n), .o_sync(wr_s));
    sync2 u_trig (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
                  .i_async(i_ecu_trigger_hit), .o_sync(trig_s));
    sync2 u_pf (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
                .i_async(i_power_fail), .o_sync(pf_s));

    // ------------------------------------------------------------
    // configuration store and state
    // ------------------------------------------------------------
    probe_state_e            st_r, st_nxt;
    logic [CS_IDX_W-1:0]     probe_cs_r, probe_cs_nxt;
    logic [CS_IDX_W-1:0]     cs0_map_r, cs0_map_nxt;
    logic                    ovr_r, ovr_nxt;
    logic [BOOT_WORD_W-1:0]  boot_word_r, boot_word_nxt;
    logic                    fwe_r, fwe_nxt;
    logic                    pwron_r, pwron_nxt;
    usage_mode_e             mode_r, mode_nxt;
    logic                    enabled_r, enabled_nxt;
    logic                    pf_d_r, pf_d_nxt;
    logic                    restore_r, restore_nxt;
    logic                    boot_drv_r, boot_drv_nxt;

    always_comb begin
        st_nxt        = st_r;
        probe_cs_nxt  = probe_cs_r;
        cs0_map_nxt   = cs0_map_r;
        ovr_nxt       = ovr_r;
        boot_word_nxt = boot_word_r;
        fwe_nxt       = fwe_r;
        pwron_nxt     = pwron_r;
        mode_nxt      = mode_r;
        enabled_nxt   = enabled_r;
        pf_d_nxt      = pf_s;
        restore_nxt   = 1'b0;
        boot_drv_nxt  = 1'b0;
        case (st_r)
            ST_LOAD: begin
                // the probe memory select stays off until storage has delivered the set; chip selects pass through unswapped
                if (i_cfg_valid) begin
                    probe_cs_nxt  = i_cfg_probe_cs;
                    cs0_map_nxt   = i_cfg_cs0_map;
                    ovr_nxt       = i_cfg_boot_override;
                    boot_word_nxt = i_cfg_boot_word;
                    fwe_nxt       = i_cfg_flash_write_en;
                    pwron_nxt     = i_cfg_power_on_active;
                    if (i_cfg_usage_mode <= 3'(MODE_DISABLED))
                        mode_nxt = usage_mode_e'(i_cfg_usage_mode);
                    else
                        mode_nxt = MODE_EMU_INIT;
                    st_nxt = ST_RESET;
                end
            end
            ST_RESET: begin
                enabled_nxt = pwron_r;
                if (rst_s) begin
                    boot_drv_nxt = ovr_r;
                    st_nxt       = ovr_r ? ST_BOOT : ST_RUN;
                end
            end
            ST_BOOT: begin
                // word held for one cycle after release as the sampling window
                st_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (!rst_s)
                    st_nxt = ST_RESET;
                else if (trig_s && !wr_s && !cs_n_s[probe_cs_r])
                    enabled_nxt = 1'b1;
            end
            default: st_nxt = ST_LOAD;
        endcase
        if (pf_s && !pf_d_r &&
            (mode_r == MODE_EMU_INIT || mode_r == MODE_RAM_INIT))
            restore_nxt = 1'b1;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r        <= ST_LOAD;
            probe_cs_r  <= CS_SEL_RESET;
            cs0_map_r   <= CS0_MAP_RESET;
            ovr_r       <= OVR_RESET;
            boot_word_r <= BOOT_WORD_RESET;
            fwe_r       <= FLASH_PROGRAM_ENABLE_LINE_RESET;
            pwron_r     <= PWRON_RESET;
            mode_r      <= MODE_EMU_INIT;
            enabled_r   <= 1'b0;
            pf_d_r      <= 1'b0;
            restore_r   <= 1'b0;
            boot_drv_r  <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            probe_cs_r  <= probe_cs_nxt;
            cs0_map_r   <= cs0_map_nxt;
            ovr_r       <= ovr_nxt;
            boot_word_r <= boot_word_nxt;
            fwe_r       <= fwe_nxt;
            pwron_r     <= pwron_nxt;
            mode_r      <= mode_nxt;
            enabled_r   <= enabled_nxt;
            pf_d_r      <= pf_d_nxt;
            restore_r   <= restore_nxt;
            boot_drv_r  <= boot_drv_nxt;
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic [CS_COUNT-1:0]    route_nxt;
    logic                   sel_nxt;
    logic                   in_run;
    logic                   drive_boot;
    logic                   svc_nxt;
    logic [CS_COUNT-1:0]    route_r;
    logic                   sel_r;
    logic                   svc_r;
    logic                   loaded_r;

    assign in_run     = (st_r == ST_RUN);
    assign drive_boot = boot_drv_nxt || (st_r == ST_BOOT && st_nxt == ST_RUN && boot_drv_r);

    always_comb begin
        route_nxt = cs_n_s;
        // remap only takes effect when a non-zero target is configured
        if (cs0_map_r != CS0_MAP_RESET) begin
            route_nxt[cs0_map_r] = cs_n_s[0];
            route_nxt[0]         = cs_n_s[cs0_map_r];
        end
        sel_nxt = in_run && (mode_r != MODE_DISABLED) && !cs_n_s[probe_cs_r] &&
                  (enabled_r || trig_s);
        svc_nxt = (mode_r == MODE_EMU_INIT) && (st_r != ST_LOAD);
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            route_r                        <= '1;
            sel_r                          <= 1'b0;
            svc_r                          <= 1'b0;
            loaded_r                       <= 1'b0;
            o_boot_data                    <= '0;
            o_boot_data_oe_n               <= 1'b1;
            o_boot_word_select_strobe_o    <= 1'b0;
            o_boot_word_select_strobe_oe_n <= 1'b1;
            o_flash_program_enable_line    <= FLASH_PROGRAM_ENABLE_LINE_RESET;
        end else begin
            route_r                        <= route_nxt;
            sel_r                          <= sel_nxt;
            svc_r                          <= svc_nxt;
            loaded_r                       <= (st_r != ST_LOAD);
            o_boot_data                    <= boot_word_r;
            o_boot_data_oe_n               <= !drive_boot;
            o_boot_word_select_strobe_o    <= 1'b0;
            o_boot_word_select_strobe_oe_n <= !drive_boot;
            o_flash_program_enable_line    <= fwe_r;
        end
    end

    assign o_cs_route_n     = route_r;
    assign o_mem_select     = sel_r;
    assign o_service_enable = svc_r;
    assign o_restore_start  = restore_r;
    assign o_probe_enabled  = enabled_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_disabled_silent: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (mode_r == MODE_DISABLED) |=> !o_mem_select)
        else $error("select in disabled mode");
    a_no_sel_loading: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !loaded_r |-> !o_mem_select)
        else $error("select before configuration loaded");
    a_inactive_trigger: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!enabled_r && !trig_s) |=> !o_mem_select)
        else $error("inactive probe selected outside trigger segment");
    a_no_override: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !ovr_r && $stable(ovr_r) |=> o_boot_data_oe_n && o_boot_word_select_strobe_oe_n)
        else $error("boot word driven without override");
    a_override_drive: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (st_r == ST_RESET && rst_s && ovr_r) |=> ##1 !o_boot_word_select_strobe_oe_n
        && !o_boot_data_oe_n && o_boot_data == boot_word_r)
        else $error("boot word not driven on release");
    a_flash_enable: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        ##1 o_flash_program_enable_line == $past(fwe_r))
        else $error("program enable line mismatch");
    a_service_mode: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (mode_r != MODE_EMU_INIT) |=> !o_service_enable)
        else $error("service offered outside normal mode");
    a_restore_mode: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (mode_r == MODE_EMU_NOINIT || mode_r == MODE_RAM_NOINIT) |=> !o_restore_start)
        else $error("restore in non-initialized mode");
    a_power_on: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (st_r == ST_RESET) |=> (o_probe_enabled == $past(pwron_r)))
        else $error("power-on state not applied");
    a_restore_init: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        ($rose(pf_s) && mode_r == MODE_RAM_INIT && $stable(mode_r)) |=> o_restore_start)
        else $error("restore missing in initialized ram mode");
endmodule

// ===== bench/ecu_bus_model.sv
// controller side model: reset pin, four chip selects, write strobe, trigger decode, power fail
`timescale 1ns/100ps
module ecu_bus_model (
    input  wire logic       i_clk_sys,
    output logic            o_ecu_reset_n,
    output logic            o_cs0_n,
    output logic            o_cs1_n,
    output logic            o_cs2_n,
    output logic            o_cs3_n,
    output logic            o_write_n,
    output logic            o_trigger_hit,
    output logic            o_power_fail
);
    logic [3:0] cs_n_r;
    assign o_cs0_n = cs_n_r[0];
    assign o_cs1_n = cs_n_r[1];
    assign o_cs2_n = cs_n_r[2];
    assign o_cs3_n = cs_n_r[3];
    initial begin
        o_ecu_reset_n = 1'b0;
        cs_n_r        = 4'hf;
        o_write_n     = 1'b1;
        o_trigger_hit = 1'b0;
        o_power_fail  = 1'b0;
    end
    task automatic set_reset(input logic v);
        @(negedge i_clk_sys);
        o_ecu_reset_n = v;
    endtask
    // a write with trigger decode high is how controller software enables the probe
    task automatic access(input int k, input logic wr_n, input logic trig);
        @(negedge i_clk_sys);
        cs_n_r        = ~(4'h1 << k);
        o_write_n     = wr_n;
        o_trigger_hit = trig;
    endtask
    // address decode is meaningless when deselected, so it must not keep its last value
    task automatic idle();
        @(negedge i_clk_sys);
        cs_n_r        = 4'hf;
        o_write_n     = 1'b1;
        o_trigger_hit = ~o_trigger_hit;
    endtask
    task automatic set_fail(input logic v);
        @(negedge i_clk_sys);
        o_power_fail = v;
    endtask
endmodule

// ===== bench/probe_ecu_config_tb.sv
// self-checking bench for the probe configuration block
`timescale 1ns/100ps
module probe_ecu_config_tb;
    import probe_cfg_pkg::*;
    logic i_clk_sys, i_reset_n, cfg_valid, ovr, fwe, pwron;
    logic [1:0]  pcs, map;
    logic [2:0]  mode;
    logic [31:0] word;
    logic [3:0]  route_n;
    logic        cs0_n, cs1_n, cs2_n, cs3_n;
    logic [31:0] boot_data;
    logic ecu_rst_n, wr_n, trig, pfail, msel, doe_n, stb_o, stb_oe_n, fpe, svc, rst_go, en;
    int   err_count, check_count, cycles, n, k;
    integer seed = 32289;
    ecu_bus_model ecu_bus_model_i (.i_clk_sys(i_clk_sys), .o_ecu_reset_n(ecu_rst_n),
        .o_cs0_n(cs0_n), .o_cs1_n(cs1_n), .o_cs2_n(cs2_n), .o_cs3_n(cs3_n),
        .o_write_n(wr_n), .o_trigger_hit(trig), .o_power_fail(pfail));
    probe_ecu_config probe_ecu_config_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_cfg_valid(cfg_valid), .i_cfg_probe_cs(pcs), .i_cfg_cs0_map(map),
        .i_cfg_boot_override(ovr), .i_cfg_boot_word(word), .i_cfg_flash_write_en(fwe),
        .i_cfg_power_on_active(pwron), .i_cfg_usage_mode(mode), .i_ecu_reset_n(ecu_rst_n),
        .i_ecu_chip_select_zero_n(cs0_n), .i_ecu_chip_select_one_n(cs1_n),
        .i_ecu_chip_select_two_n(cs2_n), .i_ecu_chip_select_three_n(cs3_n),
        .i_ecu_write_n(wr_n), .i_ecu_trigger_hit(trig), .i_power_fail(pfail),
        .o_cs_route_n(route_n), .o_mem_select(msel), .o_boot_data(boot_data),
        .o_boot_data_oe_n(doe_n), .o_boot_word_select_strobe_o(stb_o),
        .o_boot_word_select_strobe_oe_n(stb_oe_n), .o_flash_program_enable_line(fpe),
        .o_service_enable(svc), .o_restore_start(rst_go), .o_probe_enabled(en));
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    task automatic tally_and_finish();
        if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // line that a pin reaches once select zero is swapped with the chosen target
    function automatic logic [3:0] exp_route(input int p, input int m);
        int idx;
        idx = (m != 0 && p == 0) ? m : (m != 0 && p == m) ? 0 : p;
        return ~(4'h1 << idx);
    endfunction
    task automatic probe_access(input logic w_n, input logic t, input logic exp);
        ecu_bus_model_i.access(pcs, w_n, t);
        repeat (5) @(negedge i_clk_sys);
        chk(msel, exp);
        ecu_bus_model_i.idle();
        repeat (4) @(negedge i_clk_sys);
    endtask
    task automatic run_one(input int it);
        // one run uses an undefined code, which must fall back to normal emulation
        mode  = (it == 13) ? 3'h7 : 3'(it % 5);
        pcs   = (it == 0) ? CS_SEL_RESET : 2'($random(seed));
        map   = (it % 2 == 0) ? CS0_MAP_RESET : 2'($random(seed));
        ovr   = (it == 0) ? OVR_RESET : 1'($random(seed));
        fwe   = (it == 0) ? FLASH_PROGRAM_ENABLE_LINE_RESET : 1'($random(seed));
        pwron = (it == 0) ? PWRON_RESET : 1'($random(seed));
        word  = $random(seed);
        @(negedge i_clk_sys);
        i_reset_n = 1'b0;
        cfg_valid = 1'b0;
        ecu_bus_model_i.set_reset(1'b0);
        repeat (3) @(negedge i_clk_sys);
        chk({route_n, msel, doe_n, fpe, svc, rst_go, en}, {4'hf, 6'h10});
        i_reset_n = 1'b1;
        if (it == 0) begin
            ecu_bus_model_i.set_reset(1'b1);
            ecu_bus_model_i.access(pcs, 1'b1, 1'b0);
            repeat (6) @(negedge i_clk_sys);
            chk(msel, 1'b0);
            ecu_bus_model_i.idle();
            ecu_bus_model_i.set_reset(1'b0);
        end
        cfg_valid = 1'b1;
        repeat (6) @(negedge i_clk_sys);
        chk(fpe, fwe);
        chk(svc, mode == 3'h0 || mode > 3'h4);
        ecu_bus_model_i.set_reset(1'b1);
        n = 0;
        repeat (12) begin
            @(negedge i_clk_sys);
            chk(stb_o, 1'b0);
            chk(stb_oe_n, doe_n);
            if (doe_n === 1'b0) begin
                n++;
                chk(boot_data, word);
            end
        end
        chk(n, ovr ? 2 : 0);
        chk(en, pwron);
        probe_access(1'b1, 1'b0, mode != 3'h4 && pwron);
        probe_access(1'b1, 1'b1, mode != 3'h4);
        probe_access(1'b0, 1'b1, mode != 3'h4);
        if (mode != 3'h4) chk(en, 1'b1);
        probe_access(1'b1, 1'b0, mode != 3'h4);
        k = $random(seed) & 3;
        // probe already enabled here, so random strobes only exercise the routing path
        ecu_bus_model_i.access(k, 1'($random(seed)), 1'($random(seed)));
        repeat (5) @(negedge i_clk_sys);
        chk(route_n, exp_route(k, map));
        ecu_bus_model_i.idle();
        ecu_bus_model_i.set_fail(1'b1);
        n = 0;
        repeat (8) begin
            @(negedge i_clk_sys);
            if (rst_go === 1'b1) n++;
        end
        chk(n, (mode == 3'h0 || mode == 3'h3 || mode > 3'h4) ? 1 : 0);
        ecu_bus_model_i.set_fail(1'b0);
        ecu_bus_model_i.set_reset(1'b0);
        repeat (6) @(negedge i_clk_sys);
        chk(en, pwron);
    endtask
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        err_count   = 0;
        check_count = 0;
        cycles      = 0;
        i_reset_n   = 1'b0;
        cfg_valid   = 1'b0;
        {pcs, map, ovr, fwe, pwron, mode, word} = '0;
        for (int it = 0; it < 15; it++) run_one(it);
        tally_and_finish();
    end
endmodule
